// [src/see_fifo.sv]
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/10ps
module see_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [W-1:0] store_q [DEPTH];
    logic [PW:0] wr_ptr_q;
    logic [PW:0] rd_ptr_q;
    wire full = (wr_ptr_q[PW] != rd_ptr_q[PW]) &&
                (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
    wire empty = (wr_ptr_q == rd_ptr_q);
    wire do_push = in_valid && !full;
    wire do_pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = store_q[rd_ptr_q[PW-1:0]];

    always_ff @(posedge ref_clk)
    begin
        if (do_push)
        begin
            store_q[wr_ptr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q + (PW+1)'(do_push);
            rd_ptr_q <= rd_ptr_q + (PW+1)'(do_pop);
        end
    end

endmodule : see_fifo

// [src/see_pkg.sv]
// Constants and types shared by the serial EEPROM target design.
package see_pkg;

    localparam int unsigned MEM_BYTES = 65536;
    localparam int unsigned PAGE_COUNT = 512;
    localparam int unsigned PAGE_BYTES = 128;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned PAGE_W = 7;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned CNT_W = 4;

    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_ID = 4'hB;
    localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
    localparam logic [CNT_W-1:0] FIRST_TX_BIT = 4'h1;
    localparam int unsigned LOCK_BIT = 10;

    // FIFO entry: {id page flag, address, data}.
    localparam int unsigned ENTRY_W = 1 + ADDR_W + BYTE_W;
    localparam int unsigned FIFO_DEPTH_DEF = 16;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam longint unsigned WR_TIME_MS = 4;
    localparam longint unsigned PS_PER_MS = 64'd1000000000;
    // Longest time: rounded down to whole clock cycles.
    localparam int unsigned WR_CYCLES_DEF =
        int'((WR_TIME_MS * PS_PER_MS) / CLK_PERIOD_PS);
    localparam int unsigned WCNT_W = 32;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_RACK = 3'b100
    } see_state_type;

    typedef enum logic [1:0] {
        PH_SEL = 2'b00,
        PH_AHI = 2'b01,
        PH_ALO = 2'b10,
        PH_DATA = 2'b11
    } see_phase_type;

endpackage : see_pkg

// [src/see_target.sv]
// Two-wire serial EEPROM target: protocol engine, array and write cycle.
`timescale 1ns/10ps
module see_target
    import see_pkg::*;
#(
    parameter int unsigned WR_CYCLES = WR_CYCLES_DEF,
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic chip_sel_addr_hi,
    input wire logic chip_sel_addr_mid,
    input wire logic chip_sel_addr_lo,
    input wire logic write_protect_in,
    output logic write_busy,
    output logic id_locked
);

    // Array storage; the id page is kept apart from the main array.
    logic [BYTE_W-1:0] mem_q [MEM_BYTES];
    logic [BYTE_W-1:0] id_mem_q [PAGE_BYTES];

    // Pin synchronisers; stage 0 feeds only stage 1.
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic [1:0] cs_hi_s_q;
    logic [1:0] cs_mid_s_q;
    logic [1:0] cs_lo_s_q;
    logic [1:0] wp_s_q;

    see_state_type state_q;
    see_phase_type phase_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [BYTE_W-1:0] rx_sh_q;
    logic [BYTE_W-1:0] tx_sh_q;
    logic [BYTE_W-1:0] rd_q;
    logic [ADDR_W-1:0] addr_q;
    logic rw_q;
    logic idpage_q;
    logic acked_q;
    logic mack_q;
    logic drive_low_q;
    logic lock_pend_q;
    logic locked_q;
    logic busy_q;
    logic [WCNT_W-1:0] wcnt_q;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ENTRY_W-1:0] fifo_out_data;

    // Next address; page-local wrap keeps writes inside one page.
    function automatic logic [ADDR_W-1:0] addr_step(
        input logic [ADDR_W-1:0] a,
        input logic in_page
    );
        logic [ADDR_W-1:0] r;
        r = a + 16'h0001;
        if (in_page)
        begin
            r = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 7'h01};
        end
        return r;
    endfunction : addr_step

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            cs_hi_s_q <= 2'h0;
            cs_mid_s_q <= 2'h0;
            cs_lo_s_q <= 2'h0;
            wp_s_q <= 2'h0;
        end
        else
        begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            cs_hi_s_q <= {cs_hi_s_q[0], chip_sel_addr_hi};
            cs_mid_s_q <= {cs_mid_s_q[0], chip_sel_addr_mid};
            cs_lo_s_q <= {cs_lo_s_q[0], chip_sel_addr_lo};
            wp_s_q <= {wp_s_q[0], write_protect_in};
        end
    end

    // Bus events, all taken from synchronised stages 1 and 2.
    wire scl_h = scl_s_q[1];
    wire sda_h = sda_s_q[1];
    wire scl_rise = scl_s_q[1] && !scl_s_q[2];
    wire scl_fall = !scl_s_q[1] && scl_s_q[2];
    wire both_high = scl_h && scl_s_q[2];
    wire bus_start = both_high && !sda_h && sda_s_q[2];
    wire bus_stop = both_high && sda_h && !sda_s_q[2];
    wire wp_on = wp_s_q[1];
    wire [2:0] cs_pins = {cs_hi_s_q[1], cs_mid_s_q[1], cs_lo_s_q[1]};

    // Byte decode at the falling edge that closes the eighth bit.
    wire byte_done = (state_q == ST_RX) && scl_fall &&
                     (bit_cnt_q == BITS_PER_BYTE);
    wire [3:0] sel_type = rx_sh_q[7:4];
    wire type_ok = (sel_type == TYPE_MEM) ||
                   (sel_type == TYPE_ID);
    wire cs_ok = (rx_sh_q[3:1] == cs_pins);
    wire sel_hit = type_ok && cs_ok && !busy_q;
    wire is_lock = idpage_q && addr_q[LOCK_BIT];
    wire id_ro = idpage_q && locked_q;
    wire data_ok = !wp_on && !id_ro && fifo_in_ready;
    wire ack_now = (phase_q == PH_SEL) ? sel_hit :
                   (phase_q == PH_DATA) ? data_ok :
                   1'b1;
    wire data_take = byte_done && (phase_q == PH_DATA) && data_ok;
    wire fifo_in_valid = data_take && !is_lock;
    wire [ENTRY_W-1:0] fifo_in_data = {idpage_q, addr_q, rx_sh_q};
    wire go_tx_from_ack = (state_q == ST_ACK) && scl_fall &&
                          acked_q && (phase_q == PH_AHI) && rw_q;
    wire go_tx_from_rack = (state_q == ST_RACK) && scl_fall && mack_q;
    wire load_tx = go_tx_from_ack || go_tx_from_rack;
    wire wr_done = (wcnt_q == WCNT_W'(WR_CYCLES - 1)) && !fifo_out_valid;
    wire wr_begin = bus_stop && !busy_q &&
                    (fifo_out_valid || lock_pend_q);
    wire entry_id = fifo_out_data[ENTRY_W-1];
    wire [ADDR_W-1:0] entry_addr = fifo_out_data[ENTRY_W-2:BYTE_W];
    wire [BYTE_W-1:0] entry_data = fifo_out_data[BYTE_W-1:0];
    wire mem_we = busy_q && fifo_out_valid;

    // Queued write bytes; the FIFO drains only during the write cycle.
    see_fifo #(
        .W(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(busy_q),
        .out_data(fifo_out_data)
    );

    // Protocol engine.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            phase_q <= PH_SEL;
            bit_cnt_q <= '0;
            rx_sh_q <= '0;
            tx_sh_q <= '0;
            addr_q <= '0;
            rw_q <= 1'b0;
            idpage_q <= 1'b0;
            acked_q <= 1'b0;
            mack_q <= 1'b0;
            drive_low_q <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_q <= ST_IDLE;
            drive_low_q <= 1'b0;
        end
        else if (bus_start)
        begin
            state_q <= ST_RX;
            phase_q <= PH_SEL;
            bit_cnt_q <= '0;
            drive_low_q <= 1'b0;
        end
        else if (load_tx)
        begin
            state_q <= ST_TX;
            tx_sh_q <= rd_q;
            drive_low_q <= ~rd_q[BYTE_W-1];
            bit_cnt_q <= FIRST_TX_BIT;
            addr_q <= addr_step(addr_q, idpage_q);
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    drive_low_q <= 1'b0;
                end
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        rx_sh_q <= {rx_sh_q[BYTE_W-2:0], sda_h};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        state_q <= ST_ACK;
                        acked_q <= ack_now;
                        drive_low_q <= ack_now;
                        unique case (phase_q)
                            PH_SEL:
                            begin
                                rw_q <= rx_sh_q[0];
                                idpage_q <= (sel_type == TYPE_ID);
                                phase_q <= PH_AHI;
                            end
                            PH_AHI:
                            begin
                                addr_q[ADDR_W-1:BYTE_W] <= rx_sh_q;
                                phase_q <= PH_ALO;
                            end
                            PH_ALO:
                            begin
                                addr_q[BYTE_W-1:0] <= rx_sh_q;
                                phase_q <= PH_DATA;
                            end
                            PH_DATA:
                            begin
                                if (data_ok)
                                begin
                                    addr_q <= addr_step(addr_q, 1'b1);
                                end
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        drive_low_q <= 1'b0;
                        bit_cnt_q <= '0;
                        if (acked_q)
                        begin
                            if (phase_q == PH_AHI && rw_q)
                            begin
                                phase_q <= PH_SEL;
                            end
                            state_q <= ST_RX;
                        end
                        else
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_q == BITS_PER_BYTE)
                        begin
                            drive_low_q <= 1'b0;
                            state_q <= ST_RACK;
                        end
                        else
                        begin
                            drive_low_q <= ~tx_sh_q[BYTE_W-2];
                            tx_sh_q <= tx_sh_q << 1;
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        mack_q <= !sda_h;
                    end
                    else if (scl_fall)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    drive_low_q <= 1'b0;
                end
            endcase
        end
    end

    // Select-with-read leaves the ack state as PH_AHI; load_tx covers it.
    // Read data follows the current address one cycle later.
    always_ff @(posedge ref_clk)
    begin
        if (idpage_q)
        begin
            rd_q <= id_mem_q[addr_q[PAGE_W-1:0]];
        end
        else
        begin
            rd_q <= mem_q[addr_q];
        end
    end

    // Byte writes touch only their own location.
    always_ff @(posedge ref_clk)
    begin
        if (mem_we && !entry_id)
        begin
            mem_q[entry_addr] <= entry_data;
        end
        if (mem_we && entry_id)
        begin
            id_mem_q[entry_addr[PAGE_W-1:0]] <= entry_data;
        end
    end

    // Write cycle timer and id page lock.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy_q <= 1'b0;
            wcnt_q <= '0;
            lock_pend_q <= 1'b0;
            locked_q <= 1'b0;
        end
        else
        begin
            if (wr_begin)
            begin
                busy_q <= 1'b1;
                wcnt_q <= '0;
            end
            else if (busy_q && wr_done)
            begin
                busy_q <= 1'b0;
            end
            else if (busy_q)
            begin
                wcnt_q <= wcnt_q + 32'h1;
            end
            if (data_take && is_lock)
            begin
                lock_pend_q <= 1'b1;
            end
            else if (busy_q && lock_pend_q)
            begin
                lock_pend_q <= 1'b0;
                locked_q <= 1'b1;
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = ~drive_low_q;
    assign write_busy = busy_q;
    assign id_locked = locked_q;

endmodule : see_target

// [tb/see_ctrl_model.sv]
// Behavioural two-wire bus controller facing the target.
`timescale 1ns/10ps
module see_ctrl_model (
    output logic scl,
    output logic sda_oe_n,
    input wire logic sda
);
    initial
    begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end

    // One bit of 48 ns; data changes mid low phase, sampled at the rise.
    task automatic clk_bit(input logic b, output logic s);
        sda_oe_n = b;
        #12;
        scl = 1'b1;
        s = sda;
        #24;
        scl = 1'b0;
        #12;
    endtask : clk_bit

    task automatic start_cond;
        sda_oe_n = 1'b1;
        #12;
        scl = 1'b1;
        #12;
        sda_oe_n = 1'b0;
        #12;
        scl = 1'b0;
        #12;
    endtask : start_cond

    task automatic stop_cond;
        sda_oe_n = 1'b0;
        #12;
        scl = 1'b1;
        #12;
        sda_oe_n = 1'b1;
        #24;
    endtask : stop_cond

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : wr_byte

    task automatic rd_byte(output logic [7:0] d, input logic more);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(!more, s);
    endtask : rd_byte
endmodule : see_ctrl_model

// [tb/see_target_assertions.sv]
// Port-level assertion checker for the serial EEPROM target.
`timescale 1ns/10ps
module see_target_assertions
    import see_pkg::*;
#(
    parameter int unsigned WR_CYCLES = WR_CYCLES_DEF,
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic write_protect_in,
    input wire logic write_busy,
    input wire logic id_locked
);
    logic [31:0] busy_cnt_q;

    // Counts the cycles of the current internal write cycle.
    always_ff @(posedge ref_clk)
    begin
        if (srst || !write_busy)
            busy_cnt_q <= '0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_drive_low_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_busy_length: assert property (
        $fell(write_busy) |-> busy_cnt_q == WR_CYCLES)
        else $error("write cycle length wrong");
    a_busy_bound: assert property (busy_cnt_q <= WR_CYCLES)
        else $error("write cycle too long");
    a_busy_quiet: assert property (write_busy |-> sda_oe_n)
        else $error("acknowledge during write cycle");
    a_wp_no_busy: assert property (
        $rose(write_busy) |-> !write_protect_in)
        else $error("write cycle while protected");
    a_busy_after_stop: assert property (
        $rose(write_busy) |-> scl_in && sda_in)
        else $error("write cycle without stop");
    a_lock_sticky: assert property (id_locked |=> id_locked)
        else $error("lock lost");
    a_lock_no_wp: assert property (
        $rose(id_locked) |-> !write_protect_in)
        else $error("lock applied while protected");
    a_drive_scl_low: assert property (
        $changed(sda_oe_n) |-> !scl_in)
        else $error("data changed while clock high");
    a_ack_stands: assert property (
        $fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("driven bit too short");

    c_write_cycle: cover property ($rose(write_busy));
    c_lock: cover property ($rose(id_locked));
    c_ack: cover property ($fell(sda_oe_n));
endmodule : see_target_assertions

bind see_target see_target_assertions #(
    .WR_CYCLES(WR_CYCLES),
    .FIFO_DEPTH(FIFO_DEPTH)
) see_target_assertions_inst (
    .ref_clk(ref_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .write_protect_in(write_protect_in), .write_busy(write_busy),
    .id_locked(id_locked)
);

// [tb/serial_eeprom_i2c_target_bench.sv]
// Self-checking bench for the serial EEPROM target.
`timescale 1ns/10ps
module serial_eeprom_i2c_target_bench
    import see_pkg::*;
;
    typedef struct packed {
        logic [2:0] pins;
        logic [7:0] sel;
        logic ack;
    } see_row_type;
    localparam int unsigned WRC = 200;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] cs_q = 3'h0;
    logic wp_q = 1'b0;
    logic scl, m_oe_n, d_oe_n, busy, locked;
    wire sda = m_oe_n & d_oe_n;
    int n_mismatch = 0;
    int check_count = 0;
    see_row_type rows[9] = '{'{3'h0, 8'hA0, 1'b1}, '{3'h5, 8'hAA, 1'b1},
        '{3'h5, 8'hBA, 1'b1}, '{3'h5, 8'hA8, 1'b0}, '{3'h5, 8'hA2, 1'b0},
        '{3'h3, 8'hA6, 1'b1}, '{3'h5, 8'h9A, 1'b0}, '{3'h5, 8'hEA, 1'b0},
        '{3'h6, 8'hAC, 1'b1}};

    always #2.5 ref_clk = ~ref_clk;

    see_target #(.WR_CYCLES(WRC)) see_target_inst (
        .ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe_n(d_oe_n), .chip_sel_addr_hi(cs_q[2]),
        .chip_sel_addr_mid(cs_q[1]), .chip_sel_addr_lo(cs_q[0]),
        .write_protect_in(wp_q), .write_busy(busy), .id_locked(locked));
    see_ctrl_model see_ctrl_model_inst (
        .scl(scl), .sda_oe_n(m_oe_n), .sda(sda));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done;
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic send(input logic [7:0] b, input logic ack);
        logic a;
        see_ctrl_model_inst.wr_byte(b, a);
        check({7'h00, a}, {7'h00, ack});
    endtask : send

    task automatic wait_busy(input logic lvl, input int lim);
        for (int i = 0; i < lim && busy !== lvl; i++)
            @(negedge ref_clk);
        if (busy !== lvl)
        begin
            n_mismatch++;
            $display("Error at %0t: write cycle wait ran out", $time);
            test_done();
        end
    endtask : wait_busy

    task automatic head(input logic [3:0] typ, input logic [15:0] a);
        see_ctrl_model_inst.start_cond();
        send({typ, 3'h5, 1'b0}, 1'b1);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
    endtask : head

    task automatic wr(input logic [3:0] typ, input logic [15:0] a,
        input logic [7:0] d[$], input int n_ack);
        head(typ, a);
        foreach (d[i])
            send(d[i], i < n_ack);
        see_ctrl_model_inst.stop_cond();
        if (n_ack == 0)
        begin
            repeat (20) @(negedge ref_clk);
            check({7'h00, busy}, 8'h00);
        end
        else
        begin
            wait_busy(1'b1, 20);
            see_ctrl_model_inst.start_cond();
            send({TYPE_MEM, 3'h5, 1'b0}, 1'b0);
            see_ctrl_model_inst.stop_cond();
            wait_busy(1'b0, WRC);
        end
    endtask : wr

    task automatic rd(input logic [3:0] typ, input logic [15:0] a,
        input logic [7:0] e[$]);
        logic [7:0] v;
        head(typ, a);
        see_ctrl_model_inst.start_cond();
        send({typ, 3'h5, 1'b1}, 1'b1);
        foreach (e[i])
        begin
            see_ctrl_model_inst.rd_byte(v, i < e.size() - 1);
            check(v, e[i]);
        end
        see_ctrl_model_inst.stop_cond();
    endtask : rd

    // Current-address read: select with read bit, no address bytes.
    task automatic cur_rd(input logic [3:0] typ, input logic [7:0] e);
        logic [7:0] v;
        see_ctrl_model_inst.start_cond();
        send({typ, 3'h5, 1'b1}, 1'b1);
        see_ctrl_model_inst.rd_byte(v, 1'b0);
        check(v, e);
        see_ctrl_model_inst.stop_cond();
    endtask : cur_rd

    initial
    begin
        logic [7:0] fill[$];
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        check({5'h00, d_oe_n, busy, locked}, 8'h04);
        repeat (4) @(posedge ref_clk);
        foreach (rows[i])
        begin
            @(posedge ref_clk);
            cs_q <= rows[i].pins;
            @(posedge ref_clk);
            see_ctrl_model_inst.start_cond();
            send(rows[i].sel, rows[i].ack);
            see_ctrl_model_inst.stop_cond();
        end
        @(posedge ref_clk);
        cs_q <= 3'h5;
        wr(TYPE_MEM, 16'h017E, '{8'h11, 8'h22, 8'h33}, 3);
        rd(TYPE_MEM, 16'h017E, '{8'h11, 8'h22});
        rd(TYPE_MEM, 16'h0100, '{8'h33});
        wr(TYPE_MEM, 16'h017F, '{8'h44}, 1);
        rd(TYPE_MEM, 16'h017E, '{8'h11, 8'h44});
        @(posedge ref_clk);
        wp_q <= 1'b1;
        wr(TYPE_MEM, 16'h017E, '{8'h55, 8'h56}, 0);
        rd(TYPE_MEM, 16'h017E, '{8'h11, 8'h44});
        @(posedge ref_clk);
        wp_q <= 1'b0;
        wr(TYPE_ID, 16'h0005, '{8'h66}, 1);
        wr(TYPE_ID, 16'h0400, '{8'h00}, 1);
        check({7'h00, locked}, 8'h01);
        wr(TYPE_ID, 16'h0005, '{8'h77}, 0);
        rd(TYPE_ID, 16'h0005, '{8'h66});
        for (int i = 0; i < 17; i++)
            fill.push_back(8'(i));
        wr(TYPE_MEM, 16'h0200, fill, 16);
        rd(TYPE_MEM, 16'h020D, '{8'h0D, 8'h0E});
        cur_rd(TYPE_MEM, 8'h0F);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        check({5'h00, d_oe_n, busy, locked}, 8'h04);
        test_done();
    end
endmodule : serial_eeprom_i2c_target_bench
